// ===== core/lssl_core.sv
// Shift register, output latch, enable gating and global brightness PWM
`timescale 1ns/1ps
`include "lssl_map.svh"
module lssl_core
(
  input wire logic mclk, // System clock, 25 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic serial_clk, // Serial shift clock pin
  input wire logic serial_in, // Serial data pin
  input wire logic latch_strobe, // Latch strobe pin
  input wire logic enable_n, // Output enable pin, active low
  input wire logic bright_load, // Pin: high while the stream carries brightness
  output logic serial_out, // Chain output, last shift stage
  output lssl_pkg::lssl_chan_t current_sinks, // Channel on when high
  output lssl_pkg::lssl_bright_t brightness // Current global brightness
);
  import lssl_pkg::*;

  logic clk_rise;
  logic din_level;
  logic lat_rise;
  logic en_n_level;
  logic bl_level;
  lssl_chan_t shift_reg;
  lssl_chan_t latch_reg;
  lssl_bright_t bright_reg;
  lssl_bright_t pwm_cnt_reg;
  lssl_chan_t sinks_reg;
  logic take_data;
  logic take_gain;
  logic pwm_wrap;
  logic slot_lit;

  // Shift one bit in at the bottom; the top bit leaves towards the chain output
  function automatic lssl_chan_t shift_one(lssl_chan_t cur, logic bit_in);
    return {cur[`LSSL_CHANNELS-2:0], bit_in};
  endfunction

  // One decoder for both strobe targets, so a data frame and a gain frame never load together
  function automatic logic strobe_hits(logic rise, logic gain_sel, logic want_gain);
    return rise && (gain_sel == want_gain);
  endfunction

  // Last slot of the duty period; the counter never reaches the all-ones value
  function automatic logic period_end(lssl_bright_t cnt);
    return cnt == (`LSSL_PWM_PERIOD - 7'h01);
  endfunction

  // A slot is lit while the counter is below the brightness value
  function automatic logic slot_on(lssl_bright_t cnt, lssl_bright_t level);
    return cnt < level;
  endfunction

  // Every pin passes two flip-flops; the shift clock and strobe use a third stage for their edge
  lssl_sync u_clk
  (
    .mclk(mclk),
    .srst(srst),
    .pin_in(serial_clk),
    .level_out(),
    .rise_out(clk_rise)
  );

  lssl_sync u_din
  (
    .mclk(mclk),
    .srst(srst),
    .pin_in(serial_in),
    .level_out(din_level),
    .rise_out()
  );

  lssl_sync u_lat
  (
    .mclk(mclk),
    .srst(srst),
    .pin_in(latch_strobe),
    .level_out(),
    .rise_out(lat_rise)
  );

  lssl_sync u_en
  (
    .mclk(mclk),
    .srst(srst),
    .pin_in(enable_n),
    .level_out(en_n_level),
    .rise_out()
  );

  lssl_sync u_bl
  (
    .mclk(mclk),
    .srst(srst),
    .pin_in(bright_load),
    .level_out(bl_level),
    .rise_out()
  );

  assign take_data = strobe_hits(lat_rise, bl_level, 1'b0);
  assign take_gain = strobe_hits(lat_rise, bl_level, 1'b1);
  assign pwm_wrap = period_end(pwm_cnt_reg);
  assign slot_lit = slot_on(pwm_cnt_reg, bright_reg);

  // Data is sampled through the same synchroniser depth as the clock, so setup and hold align
  always_ff @(posedge mclk)
  begin
    if (srst)
      shift_reg <= `LSSL_SHIFT_RESET;
    else if (clk_rise)
      shift_reg <= shift_one(shift_reg, din_level); // see R1
  end

  assign serial_out = shift_reg[`LSSL_CHANNELS-1]; // see R8

  // Latch updates only on the strobe edge; brightness frames do not touch channel data
  always_ff @(posedge mclk)
  begin
    if (srst)
      latch_reg <= `LSSL_LATCH_RESET;
    else if (take_data)
      latch_reg <= shift_reg; // see R3 see R4
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      bright_reg <= `LSSL_BRIGHT_RESET;
    else if (take_gain)
      bright_reg <= shift_reg[`LSSL_BRIGHT_BITS-1:0]; // see R7
  end

  assign brightness = bright_reg;

  always_ff @(posedge mclk)
  begin
    if (srst)
      pwm_cnt_reg <= 7'h00;
    else if (pwm_wrap)
      pwm_cnt_reg <= 7'h00;
    else
      pwm_cnt_reg <= pwm_cnt_reg + 7'h01;
  end

  // Brightness as duty cycle over 127 slots; full scale keeps channels on continuously
  always_ff @(posedge mclk)
  begin
    if (srst)
      sinks_reg <= '0;
    else if (en_n_level)
      sinks_reg <= '0; // see R5
    else if (slot_lit)
      sinks_reg <= latch_reg; // see R2 see R6 see R7
    else
      sinks_reg <= '0;
  end

  assign current_sinks = sinks_reg;
endmodule

// ===== common/lssl_map.svh
// Constants and rule summary for the LED sink shift-latch block
// What this block does
// R1: Each serial clock rising edge shifts serial_in into the shift register.
// R2: Eight current-sink channels, each switched by one latched bit.
// R3: Latch strobe rising edge with bright_load low copies the shift register into the output latch.
// R4: Output latch holds its value at all other times, whatever shifting happens.
// R5: Output enable high (active low pin) turns every channel off.
// R6: Output enable low lets every channel follow its latched bit during the lit slots of the brightness duty period.
// R7: A seven-bit global brightness value, shifted in serially, scales all channels.
// R8: Last shift stage drives serial_out so devices can be chained.
`ifndef LSSL_MAP_SVH
`define LSSL_MAP_SVH
`define LSSL_CHANNELS 8
`define LSSL_BRIGHT_BITS 7
`define LSSL_SHIFT_RESET 8'h00
`define LSSL_LATCH_RESET 8'h00
`define LSSL_BRIGHT_RESET 7'h7f
`define LSSL_PWM_PERIOD 7'h7f
`endif

// ===== common/lssl_pkg.sv
// Types shared by the LED sink shift-latch block
`include "lssl_map.svh"
package lssl_pkg;
  typedef logic [`LSSL_CHANNELS-1:0] lssl_chan_t;
  typedef logic [`LSSL_BRIGHT_BITS-1:0] lssl_bright_t;
endpackage

// ===== core/lssl_sync.sv
// Two-flip-flop synchroniser with rising-edge detect on the synchronised level
`timescale 1ns/1ps
module lssl_sync
(
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic pin_in, // Asynchronous pin
  output logic level_out, // Synchronised level
  output logic rise_out // One-cycle pulse on rising edge
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  assign level_out = stage2_reg;
  assign rise_out = stage2_reg & ~stage3_reg;
endmodule

// ===== tb/lssl_core_props.sv
// Port assertions for the LED sink shift-latch core
`timescale 1ns/1ps
module lssl_core_props (
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic serial_clk, // Shift clock
  input wire logic latch_strobe, // Strobe
  input wire logic enable_n, // Enable
  input wire logic bright_load, // Gain select
  input wire logic serial_out, // Chain out
  input wire lssl_pkg::lssl_chan_t current_sinks, // Sinks
  input wire lssl_pkg::lssl_bright_t brightness // Gain
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  rst_vals_a: assert property ($fell(srst) |-> !serial_out && current_sinks == 0 && &brightness) else $error("reset");
  sinks_off_a: assert property (enable_n [*5] |-> current_sinks == 0) else $error("lit while off");
  sinks_on_a: assert property (|current_sinks |-> !$past(enable_n, 3) || !$past(enable_n, 4)) else $error("lit");
  shift_time_a: assert property ($changed(serial_out) |-> $past(serial_clk, 3) && !$past(serial_clk, 4)) else $error("shift");
  gain_strobe_a: assert property ($changed(brightness) |-> $past(latch_strobe, 3) && !$past(latch_strobe, 4)) else $error("gain");
  gain_select_a: assert property ($changed(brightness) |-> $past(bright_load, 3)) else $error("gain select");
  dark_zero_a: assert property ((brightness == 0) [*3] |-> current_sinks == 0) else $error("lit at zero gain");
  sinks_hold_a: assert property ($changed(current_sinks) && &brightness && $stable(brightness)
    && $past(brightness, 2) == 7'h7f |->
    $past(latch_strobe, 4) && !$past(latch_strobe, 5) || $past(enable_n, 3) != $past(enable_n, 4)) else $error("hold");
endmodule

// ===== tb/lssl_ctrl_model.sv
// Display controller model that shifts bytes into the chain and strobes them
`timescale 1ns/1ps
module lssl_ctrl_model (
  input wire logic mclk, // Clock
  output logic sclk = 1'b0, // Idle low between frames
  output logic sdata = 1'b0, // Serial data
  output logic strobe = 1'b0 // Latch strobe
);
  // Gap sets each clock phase; 1 is the fastest the core accepts
  task automatic send(logic [7:0] v, int gap, logic st);
    strobe <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      {sdata, sclk} <= {v[i / 2], ~i[0]};
      repeat (gap) @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
    {sclk, strobe} <= {1'b0, st};
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ===== tb/lssl_core_tb.sv
// Random and corner-case bench for the LED sink shift-latch core
`timescale 1ns/1ps
`include "lssl_map.svh"
module lssl_core_tb;
  logic mclk = 0, srst = 1, en_n = 1, bl = 0, sck, sdi, lat, sdo;
  logic [7:0] q, v, x;
  logic [6:0] g;
  logic [6:0] gx = `LSSL_BRIGHT_RESET;
  int lit = 0, bad = 0;
  logic [31:0] s = 32'haa5c0e7e;
  int fails = 0, comparisons = 0;
  always #20 mclk = ~mclk;
  lssl_ctrl_model ctrl_u (.mclk(mclk), .sclk(sck), .sdata(sdi), .strobe(lat));
  lssl_core dut_u (.mclk(mclk), .srst(srst), .serial_clk(sck), .serial_in(sdi), .latch_strobe(lat),
    .enable_n(en_n), .bright_load(bl), .serial_out(sdo), .current_sinks(q), .brightness(g));
  function automatic logic [31:0] xs(logic [31:0] a);
    a ^= a << 13;
    a ^= a >> 17;
    return a ^ (a << 5);
  endfunction
  function automatic logic [7:0] want_sinks(logic off, logic [7:0] d);
    return off ? 8'h00 : d;
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    fails += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %0t got %h want %h", $time, got, exp);
  endtask
  task automatic give_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    srst <= 0;
    // Pass 3 shifts without a strobe, pass 4 is disabled, pass 8 loads zero gain, pass 9 a random gain
    for (int k = 0; k < 10; k++)
    begin
      @(posedge mclk);
      s = xs(s);
      v = k == 0 ? 8'h80 : k == 8 ? 8'h00 : s[7:0];
      if (k != 3 && k < 8) x = v;
      if (k >= 8) gx = v[6:0];
      en_n <= k == 4;
      bl <= k >= 8;
      ctrl_u.send(v, k[0] ? 5 : 2, k != 3);
      repeat (17) @(mclk);
      if (k < 9) chk(q, want_sinks(en_n || gx == 7'h00, x));
      chk({7'h00, sdo}, {7'h00, v[7]});
      chk({1'b0, g}, {1'b0, gx});
    end
    // Over one duty period the latched data is lit for as many slots as the gain value
    repeat (`LSSL_PWM_PERIOD)
    begin
      @(negedge mclk);
      lit += int'(q !== 8'h00);
      bad += int'(q !== 8'h00 && q !== x);
    end
    chk(lit[7:0], x == 8'h00 ? 8'h00 : {1'b0, gx});
    chk(bad[7:0], 8'h00);
    @(posedge mclk);
    srst <= 1;
    repeat (3) @(posedge mclk);
    srst <= 0;
    @(negedge mclk);
    chk(q, 8'h00);
    chk({7'h00, sdo}, 8'h00);
    chk({1'b0, g}, {1'b0, `LSSL_BRIGHT_RESET});
    give_verdict();
  end
endmodule
bind lssl_core lssl_core_props props_u (.*);
